// ---- include/dib_pkg.sv ----
// shared constants and types for the inter-bank command block
// assumes a single 200 MHz clock domain and a four-bank device
package dib_pkg;

    localparam int NUM_BANKS = 4;
    localparam int BANK_W = 2;
    localparam int ADDR_W = 13;
    localparam int AP_BIT = 10;

    // timing figures in device clocks
    localparam int BURST_LEN = 4;
    localparam int CAS_LAT = 3;
    localparam int T_RCD = 3;
    localparam int T_RP = 3;
    localparam int T_WR = 3;
    localparam int T_WTR = 1;
    localparam int T_RFC = 14;
    localparam int T_MRD = 2;
    localparam int CNT_W = 5;

    // timer load values and limits, including the access period lengths of auto-precharge bursts
    localparam logic [CNT_W-1:0] RD_ACCESS_CYC = CNT_W'(BURST_LEN / 2);
    localparam logic [CNT_W-1:0] WR_ACCESS_CYC = CNT_W'(1 + BURST_LEN / 2 + T_WR);
    localparam logic [CNT_W-1:0] RD_BURST_CYC = CNT_W'(BURST_LEN / 2);
    localparam logic [CNT_W-1:0] WR_BURST_CYC = CNT_W'(BURST_LEN / 2);
    localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'(T_RCD);
    localparam logic [CNT_W-1:0] RP_CYC = CNT_W'(T_RP);
    localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'(T_RFC);
    localparam logic [CNT_W-1:0] MRD_CYC = CNT_W'(T_MRD);
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] RD_AP_TO_WR_CYC = CNT_W'(CAS_LAT + BURST_LEN / 2);
    localparam logic [CNT_W-1:0] AP_GAP_MAX = 5'h1F;

    typedef enum logic [3:0] {
        CMD_DESELECT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
        CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_SET, CMD_TERMINATE
    } dib_cmd_t;

    typedef enum logic [3:0] {
        BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
        BK_RD_AP_ACCESS, BK_WR_AP_ACCESS, BK_AP_PRECHARGE, BK_PRECHARGING
    } dib_bank_t;

endpackage

// ---- include/dib_bank_if.sv ----
// per-bank command strobes and state returns between decoder and trackers
// assumes the decoder and the trackers share clk_sys
interface dib_bank_if;
    import dib_pkg::*;
    logic hit;
    dib_cmd_t cmd;
    logic autoPrecharge;
    logic allPrecharge;
    dib_bank_t state;

    modport decoder (output hit, output cmd, output autoPrecharge, output allPrecharge, input state);
    modport tracker (input hit, input cmd, input autoPrecharge, input allPrecharge, output state);
endinterface

// ---- hw/dib_bank_tracker.sv ----
// state of one bank, driven by decoded commands
// assumes commands arrive already registered on clk_sys
module dib_bank_tracker
    import dib_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    dib_bank_if.tracker bus
);

    dib_bank_t state;
    logic [CNT_W-1:0] timer;
    logic timerDone;

    assign timerDone = (timer == CNT_ZERO);
    assign bus.state = state;

    // =========================================
    // bank state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= BK_IDLE;
            timer <= CNT_ZERO;
        end else if ((bus.hit || bus.allPrecharge) && bus.cmd == CMD_PRECHARGE) begin
            state <= BK_PRECHARGING;
            timer <= RP_CYC;
        end else if (bus.hit && bus.cmd == CMD_ACTIVE) begin
            state <= BK_ACTIVATING;
            timer <= RCD_CYC;
        end else if (bus.hit && bus.cmd == CMD_READ) begin
            state <= bus.autoPrecharge ? BK_RD_AP_ACCESS : BK_READ;
            timer <= bus.autoPrecharge ? RD_ACCESS_CYC : RD_BURST_CYC;
        end else if (bus.hit && bus.cmd == CMD_WRITE) begin
            state <= bus.autoPrecharge ? BK_WR_AP_ACCESS : BK_WRITE;
            timer <= bus.autoPrecharge ? WR_ACCESS_CYC : WR_BURST_CYC;
        end else if (bus.hit && bus.cmd == CMD_TERMINATE && state == BK_READ) begin
            state <= BK_ACTIVE;
            timer <= CNT_ZERO;
        end else if (!timerDone) begin
            timer <= timer - 5'h01;
        end else begin
            case (state)
                BK_ACTIVATING: state <= BK_ACTIVE;
                BK_READ, BK_WRITE: state <= BK_ACTIVE;
                BK_RD_AP_ACCESS, BK_WR_AP_ACCESS: begin
                    state <= BK_AP_PRECHARGE;
                    timer <= RP_CYC;
                end
                BK_AP_PRECHARGE, BK_PRECHARGING: state <= BK_IDLE;
                default: state <= state;
            endcase
        end
    end

endmodule

// ---- hw/dib_command_decoder.sv ----
// command decoder and per-bank state tracking for a four-bank DDR device
// assumes command pins are synchronous to clk_sys and clock enable is held high

// Summary of operation
// - deselect or no-operation cycles change nothing and let operations continue
// - active, read, write, precharge decoded from row, column, write strobes
// - read auto-precharge period starts at earliest lossless precharge point
// - write auto-precharge period starts when write recovery expires
// - burst terminate acts only on the bank with a read burst in progress
// - idle after precharge plus row precharge time; active after activate delay
// - read state lasts from burst start to completion or terminate; write state lasts from burst start to completion
module dib_command_decoder
    import dib_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic chipSelect_n,
    input wire logic rowStrobe_n,
    input wire logic colStrobe_n,
    input wire logic writeEnable_n,
    input wire logic [BANK_W-1:0] bankAddr,
    input wire logic [ADDR_W-1:0] addr,
    output logic [NUM_BANKS-1:0] bankIdle,
    output logic [NUM_BANKS-1:0] bankActive,
    output logic [NUM_BANKS-1:0] bankBursting,
    output logic [NUM_BANKS-1:0] bankAutoPrecharge,
    output logic allIdle,
    output logic globalBusy,
    output logic illegalCmd
);

    dib_cmd_t cmd;
    logic [BANK_W-1:0] cmdBank;
    logic cmdAp;
    logic [CNT_W-1:0] globalTimer;
    logic [NUM_BANKS-1:0] idleVec;
    logic [NUM_BANKS-1:0] apAccessVec;
    dib_bank_t stateVec [NUM_BANKS];
    logic next_illegal;
    logic [BANK_W-1:0] apBank;
    logic apWasWrite;
    logic [CNT_W-1:0] apGap;
    logic apSpacingBad;

    dib_bank_if bankBus[NUM_BANKS] ();

    // =========================================
    // command decode, one per rising edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cmd <= CMD_DESELECT;
            cmdBank <= 2'h0;
            cmdAp <= 1'b0;
        end else begin
            cmdBank <= bankAddr;
            cmdAp <= addr[AP_BIT];
            if (chipSelect_n) begin
                cmd <= CMD_DESELECT;
            end else begin
                case ({rowStrobe_n, colStrobe_n, writeEnable_n})
                    3'h7: cmd <= CMD_NOP;
                    3'h3: cmd <= CMD_ACTIVE;
                    3'h5: cmd <= CMD_READ;
                    3'h4: cmd <= CMD_WRITE;
                    3'h2: cmd <= CMD_PRECHARGE;
                    3'h1: cmd <= CMD_REFRESH;
                    3'h0: cmd <= CMD_MODE_SET;
                    default: cmd <= CMD_TERMINATE;
                endcase
            end
        end
    end

    // =========================================
    // bank trackers
    genvar gb;
    generate
        for (gb = 0; gb < NUM_BANKS; gb++) begin : gBank
            assign bankBus[gb].hit = (cmdBank == BANK_W'(gb)) && (globalTimer == CNT_ZERO);
            assign bankBus[gb].cmd = cmd;
            assign bankBus[gb].autoPrecharge = cmdAp;
            assign bankBus[gb].allPrecharge = cmdAp && (globalTimer == CNT_ZERO);
            assign stateVec[gb] = bankBus[gb].state;
            assign idleVec[gb] = (bankBus[gb].state == BK_IDLE);
            assign apAccessVec[gb] = (bankBus[gb].state == BK_RD_AP_ACCESS)
                || (bankBus[gb].state == BK_WR_AP_ACCESS);
            dib_bank_tracker uTracker (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .bus(bankBus[gb])
            );
        end
    endgenerate

    // =========================================
    // all-bank operations hold off bank commands
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            globalTimer <= CNT_ZERO;
        end else if (globalTimer != CNT_ZERO) begin
            globalTimer <= globalTimer - 5'h01;
        end else if (cmd == CMD_REFRESH && (&idleVec)) begin
            globalTimer <= RFC_CYC;
        end else if (cmd == CMD_MODE_SET && (&idleVec)) begin
            globalTimer <= MRD_CYC;
        end else if (cmd == CMD_PRECHARGE && cmdAp) begin
            globalTimer <= RP_CYC;
        end
    end

    // =========================================
    // last auto-precharge burst and cycles since it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            apBank <= 2'h0;
            apWasWrite <= 1'b0;
            apGap <= AP_GAP_MAX;
        end else if ((cmd == CMD_READ || cmd == CMD_WRITE) && cmdAp && (globalTimer == CNT_ZERO)) begin
            apBank <= cmdBank;
            apWasWrite <= (cmd == CMD_WRITE);
            apGap <= 5'h01;
        end else if (apGap != AP_GAP_MAX) begin
            apGap <= apGap + 5'h01;
        end
    end

    // =========================================
    // column command too close to another bank's auto-precharge burst
    always_comb begin
        apSpacingBad = 1'b0;
        if (cmdBank != apBank) begin
            if (apWasWrite) begin
                apSpacingBad = (apGap < WR_ACCESS_CYC);
            end else if (cmd == CMD_WRITE) begin
                apSpacingBad = (apGap < RD_AP_TO_WR_CYC);
            end else begin
                apSpacingBad = (apGap < RD_ACCESS_CYC);
            end
        end
    end

    // =========================================
    // legality check on the decoded command
    always_comb begin
        next_illegal = 1'b0;
        if (globalTimer != CNT_ZERO) begin
            next_illegal = (cmd != CMD_DESELECT) && (cmd != CMD_NOP);
        end else begin
            case (cmd)
                CMD_REFRESH, CMD_MODE_SET: next_illegal = !(&idleVec);
                CMD_READ, CMD_WRITE: begin
                    // other bank still in auto-precharge access period, or a write within 5 cycles of a read auto-precharge
                    if (apSpacingBad) begin
                        next_illegal = 1'b1;
                    end
                    if (stateVec[cmdBank] != BK_ACTIVE && stateVec[cmdBank] != BK_READ
                        && stateVec[cmdBank] != BK_WRITE) begin
                        next_illegal = 1'b1;
                    end
                end
                CMD_ACTIVE: next_illegal = !idleVec[cmdBank];
                CMD_TERMINATE: next_illegal = (stateVec[cmdBank] != BK_READ);
                default: next_illegal = 1'b0;
            endcase
        end
    end

    // =========================================
    // registered per-bank status outputs
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bankIdle <= 4'hF;
            bankActive <= 4'h0;
            bankBursting <= 4'h0;
            bankAutoPrecharge <= 4'h0;
        end else begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                bankActive[i] <= (stateVec[i] == BK_ACTIVE);
                bankBursting[i] <= (stateVec[i] == BK_READ) || (stateVec[i] == BK_WRITE);
                bankAutoPrecharge[i] <= apAccessVec[i] || (stateVec[i] == BK_AP_PRECHARGE);
            end
            bankIdle <= idleVec;
        end
    end

    // =========================================
    // registered device-wide status
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            allIdle <= 1'b1;
            globalBusy <= 1'b0;
        end else begin
            allIdle <= &idleVec;
            globalBusy <= (globalTimer != CNT_ZERO);
        end
    end

    // =========================================
    // sticky error flag, cleared only by reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            illegalCmd <= 1'b0;
        end else if (next_illegal) begin
            illegalCmd <= 1'b1;
        end
    end

endmodule

// ---- bench/dib_ctrl_model.sv ----
// controller model driving the command pins
// assumes clk_sys from the bench; pins change 1 ns after a rising edge
module dib_ctrl_model
    import dib_pkg::*;
(
    input wire logic clk_sys,
    output logic chipSelect_n,
    output logic rowStrobe_n,
    output logic colStrobe_n,
    output logic writeEnable_n,
    output logic [BANK_W-1:0] bankAddr,
    output logic [ADDR_W-1:0] addr
);
    timeunit 1ns;
    timeprecision 100ps;
    int seed = 16696;
    initial begin
        {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = 4'hF;
        bankAddr = 2'h0;
        addr = 13'h0000;
    end
    // clock enable held high, no self refresh
    // no data bus here: column commands spaced so data never collides, except back-to-back pairs in the access period and write ap too close tests
    // device side supports concurrent auto-precharge
    // one command held for one cycle
    task automatic send(input logic [3:0] pins, input logic [1:0] bank, input logic ap);
        @(posedge clk_sys);
        #1;
        {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = pins;
        bankAddr = bank;
        addr = 13'($random(seed));
        addr[AP_BIT] = ap;
    endtask
    // random deselect or no-operation cycles
    task automatic idle(input int n);
        repeat (n) send(($random(seed) & 1) ? 4'h7 : {1'b1, 3'($random(seed))}, 2'($random(seed)), 1'b0);
    endtask
endmodule

// ---- bench/dib_command_decoder_assertions.sv ----
// port-level checks of the inter-bank decoder
// assumes binding to dib_command_decoder in one clk_sys domain
module dib_command_decoder_assertions
    import dib_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic chipSelect_n,
    input wire logic rowStrobe_n,
    input wire logic colStrobe_n,
    input wire logic writeEnable_n,
    input wire logic [BANK_W-1:0] bankAddr,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [NUM_BANKS-1:0] bankIdle,
    input wire logic [NUM_BANKS-1:0] bankActive,
    input wire logic [NUM_BANKS-1:0] bankBursting,
    input wire logic [NUM_BANKS-1:0] bankAutoPrecharge,
    input wire logic globalBusy,
    input wire logic illegalCmd
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] pins;
    logic isAct, isRd, isNop, rdAp0;
    assign pins = {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n};
    assign isAct = pins == 4'h3;
    assign isRd = pins == 4'h5;
    assign isNop = pins[3] || pins == 4'h7;
    assign rdAp0 = isRd && addr[AP_BIT] && bankAddr == 2'h0 && bankActive[0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_nop_hold; isNop [*4] ##0 bankActive[0] |=> bankActive[0]; endproperty
    a_nop_hold: assert property (p_nop_hold) else $error("bank lost on idle cycles");
    property p_act; isAct && bankAddr == 2'h0 && bankIdle[0] && !globalBusy |-> ##[1:4] !bankIdle[0] ##[1:6] bankActive[0]; endproperty
    a_act: assert property (p_act) else $error("activate not tracked");
    property p_rd_ap; rdAp0 |-> ##[1:4] bankAutoPrecharge[0] ##[2:16] bankIdle[0]; endproperty
    a_rd_ap: assert property (p_rd_ap) else $error("auto precharge read not closed");
    property p_ap_block; rdAp0 ##1 (isRd || pins == 4'h4) && bankAddr != 2'h0 |-> ##[1:3] illegalCmd; endproperty
    a_ap_block: assert property (p_ap_block) else $error("access period column command accepted");
    property p_ap_other; rdAp0 ##1 isAct && bankAddr == 2'h2 && bankIdle[2] && !illegalCmd |-> ##3 !illegalCmd; endproperty
    a_ap_other: assert property (p_ap_other) else $error("activate after one cycle refused");
    property p_ref_bad; pins == 4'h1 && !bankIdle[3] && !globalBusy |-> ##[1:3] illegalCmd; endproperty
    a_ref_bad: assert property (p_ref_bad) else $error("refresh with open bank accepted");
    property p_burst; isRd && !addr[AP_BIT] && bankAddr == 2'h1 && bankActive[1] |-> ##[1:3] bankBursting[1]; endproperty
    a_burst: assert property (p_burst) else $error("read burst not tracked");
    property p_busy; globalBusy && $past(globalBusy) && $past(globalBusy, 2) && isAct |-> ##[1:3] illegalCmd; endproperty
    a_busy: assert property (p_busy) else $error("command during busy accepted");
    property p_sticky; illegalCmd |=> illegalCmd; endproperty
    a_sticky: assert property (p_sticky) else $error("error flag dropped");
    cover property (rdAp0);
    cover property (globalBusy);
    cover property ($rose(illegalCmd));
endmodule
bind dib_command_decoder dib_command_decoder_assertions u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeEnable_n(writeEnable_n),
    .bankAddr(bankAddr), .addr(addr), .bankIdle(bankIdle), .bankActive(bankActive),
    .bankBursting(bankBursting), .bankAutoPrecharge(bankAutoPrecharge), .globalBusy(globalBusy),
    .illegalCmd(illegalCmd));

// ---- bench/tb_dib_command_decoder.sv ----
// self-checking bench for the inter-bank command decoder
// assumes the controller model and the bound checker
`define DIB_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module tb_dib_command_decoder
    import dib_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] P_ACT = 4'h3;
    localparam logic [3:0] P_RD = 4'h5;
    localparam logic [3:0] P_WR = 4'h4;
    localparam logic [3:0] P_PRE = 4'h2;
    localparam logic [3:0] P_REF = 4'h1;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n;
    logic [BANK_W-1:0] bankAddr;
    logic [ADDR_W-1:0] addr;
    logic [NUM_BANKS-1:0] bankIdle, bankActive, bankBursting, bankAutoPrecharge;
    logic allIdle, globalBusy, illegalCmd;
    logic [17:0] notes[$];
    logic [17:0] nt;
    int err_count = 0;
    int num_checks = 0;
    event probe;
    always #2.5 clk_sys = ~clk_sys;
    dib_ctrl_model u_ctrl (.clk_sys(clk_sys), .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n),
        .colStrobe_n(colStrobe_n), .writeEnable_n(writeEnable_n), .bankAddr(bankAddr), .addr(addr));
    dib_command_decoder u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .chipSelect_n(chipSelect_n),
        .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeEnable_n(writeEnable_n),
        .bankAddr(bankAddr), .addr(addr), .bankIdle(bankIdle), .bankActive(bankActive),
        .bankBursting(bankBursting), .bankAutoPrecharge(bankAutoPrecharge), .allIdle(allIdle),
        .globalBusy(globalBusy), .illegalCmd(illegalCmd));
    // note {error, idle, active} expectation, ends a test
    task automatic note(input logic [8:0] mask, input logic [8:0] exp, input string name);
        @(posedge clk_sys);
        #2;
        notes.push_back({mask, exp});
        -> probe;
        $display("test %s done", name);
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(probe) begin
        nt = notes.pop_front();
        `DIB_CHK({illegalCmd, bankIdle, bankActive} & nt[17:9], nt[8:0])
        if (nt[16:13] == 4'hF) `DIB_CHK(allIdle, &nt[7:4])
    end
    initial begin
        do_reset();
        note(9'h1FF, 9'h0F0, "reset");
        u_ctrl.send(P_ACT, 2'h0, 1'b0);
        u_ctrl.send(P_ACT, 2'h1, 1'b0);
        u_ctrl.idle(12);
        note(9'h1FF, 9'h0C3, "activate");
        u_ctrl.send(P_RD, 2'h0, 1'b1);
        u_ctrl.send(P_ACT, 2'h2, 1'b0);
        u_ctrl.idle(16);
        note(9'h1FF, 9'h096, "read auto precharge");
        u_ctrl.send(P_WR, 2'h1, 1'b0);
        u_ctrl.idle(10);
        note(9'h1FF, 9'h096, "write burst");
        u_ctrl.send(P_PRE, 2'h1, 1'b0);
        u_ctrl.send(P_PRE, 2'h2, 1'b0);
        u_ctrl.idle(8);
        note(9'h1FF, 9'h0F0, "precharge");
        u_ctrl.send(P_REF, 2'h0, 1'b0);
        u_ctrl.idle(20);
        note(9'h1FF, 9'h0F0, "refresh");
        u_ctrl.send(P_ACT, 2'h0, 1'b0);
        u_ctrl.send(P_ACT, 2'h1, 1'b0);
        u_ctrl.idle(8);
        u_ctrl.send(P_RD, 2'h0, 1'b1);
        u_ctrl.send(P_RD, 2'h1, 1'b0);
        u_ctrl.idle(20);
        note(9'h100, 9'h100, "access period");
        do_reset();
        note(9'h1FF, 9'h0F0, "second reset");
        u_ctrl.send(P_REF, 2'h0, 1'b0);
        u_ctrl.idle(3);
        u_ctrl.send(P_ACT, 2'h0, 1'b0);
        u_ctrl.idle(4);
        note(9'h100, 9'h100, "busy refusal");
        do_reset();
        u_ctrl.send(P_ACT, 2'h3, 1'b0);
        u_ctrl.idle(6);
        u_ctrl.send(P_REF, 2'h0, 1'b0);
        u_ctrl.idle(4);
        note(9'h100, 9'h100, "refresh open bank");
        do_reset();
        u_ctrl.send(P_ACT, 2'h0, 1'b0);
        u_ctrl.send(P_ACT, 2'h1, 1'b0);
        u_ctrl.send(P_ACT, 2'h2, 1'b0);
        u_ctrl.idle(6);
        u_ctrl.send(P_WR, 2'h0, 1'b1);
        u_ctrl.idle(5);
        u_ctrl.send(P_RD, 2'h1, 1'b0);
        u_ctrl.idle(4);
        note(9'h100, 9'h000, "write ap spacing");
        u_ctrl.send(P_WR, 2'h1, 1'b1);
        u_ctrl.send(P_RD, 2'h2, 1'b0);
        u_ctrl.idle(4);
        note(9'h100, 9'h100, "write ap too close");
        test_done();
    end
    initial begin
        #5000;
        err_count++;
        test_done();
    end
endmodule
